// ---- dv/acc_math_mem_model.sv ----
// word memory model standing behind the math unit
`timescale 1ns/100ps
`default_nettype none
module acc_math_mem_model #(
	parameter ADDR_W = 16
) (
	// clock
	input  wire logic              i_clk_sys,
	// memory port from the unit
	input  wire logic              i_rd,
	input  wire logic              i_wr,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [15:0]       i_wdata,
	output logic      [15:0]       o_rdata
);
	logic [15:0] mem [0:255];       // small window of data words
	logic [15:0] last_reg = 16'h0;  // last word handed out
	// the unit latches read data at the edge that samples its read strobe
	always @(posedge i_clk_sys) begin
		if (i_rd) last_reg <= mem[i_addr[7:0]];
		if (i_wr) mem[i_addr[7:0]] <= i_wdata;
	end
	// outside a read show the inverse of the last word, so stale data is never taken as valid
	assign o_rdata = i_rd ? mem[i_addr[7:0]] : ~last_reg;
endmodule // acc_math_mem_model
`default_nettype wire

// ---- dv/accumulator_math_unit_properties.sv ----
// assertions on the math unit ports
`timescale 1ns/100ps
`default_nettype none
`include "acc_math_defs.vh"
module accumulator_math_unit_properties #(
	parameter ADDR_W = 16
) (
	// clock and reset
	input wire logic                   i_clk_sys,
	input wire logic                   i_reset_n,
	// request
	input wire logic                   i_op_valid,
	input wire logic [3:0]             i_op_code,
	input wire logic                   i_op_immediate,
	input wire logic [31:0]            i_op_constant,
	input wire logic [ADDR_W-1:0]      i_op_addr,
	input wire logic                   i_op_pointer_bad,
	input wire logic                   o_op_ready,
	input wire logic                   o_op_done,
	// results and memory
	input wire logic                   o_mem_rd,
	input wire logic [ADDR_W-1:0]      o_mem_addr,
	input wire logic [31:0]            o_accumulator,
	input wire logic [31:0]            o_stack_first,
	input wire logic [`FLAG_COUNT-1:0] o_flags
);
	logic              take;     // request accepted this edge
	logic              fin;      // immediate op finishing
	logic              bin;      // binary sum or difference op finishing
	logic [3:0]        op_reg;   // op in flight
	logic [31:0]       a_reg;    // accumulator at take
	logic [15:0]       b_reg;    // low constant at take
	logic              imm_reg;  // operand was a constant
	logic              pb_reg;   // pointer was bad
	logic [ADDR_W-1:0] addr_reg; // operand address
	assign take = i_op_valid && o_op_ready;
	assign fin = o_op_done && imm_reg;
	assign bin = o_op_done && (op_reg == `OP_SUM_BINARY16 || op_reg == `OP_DIFFERENCE_BINARY16);
	// capture the cause of each op so its result can be judged at done
	always @(posedge i_clk_sys) begin
		if (take) begin
			op_reg <= i_op_code;
			a_reg <= o_accumulator;
			b_reg <= i_op_constant[15:0];
			imm_reg <= i_op_immediate;
			pb_reg <= i_op_pointer_bad;
			addr_reg <= i_op_addr;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	sequence s_word_lo; o_mem_rd && o_mem_addr == addr_reg; endsequence
	sequence s_word_hi; o_mem_rd && o_mem_addr == addr_reg + ADDR_W'(1); endsequence
	property p_sum; fin && op_reg == `OP_SUM_BINARY16 |-> o_accumulator == a_reg[15:0] + b_reg; endproperty
	property p_carry; fin && op_reg == `OP_SUM_BINARY16 |-> o_flags[`FLAG_CARRY16] == o_accumulator[16]; endproperty
	property p_diff; fin && op_reg == `OP_DIFFERENCE_BINARY16 |-> o_accumulator == a_reg - b_reg
		&& o_flags[`FLAG_BORROW32] == (a_reg < b_reg); endproperty
	property p_prod; fin && op_reg == `OP_PRODUCT_BINARY16 |-> o_accumulator == a_reg[15:0] * b_reg; endproperty
	property p_zero; bin |-> o_flags[`FLAG_ZERO] == (o_accumulator == 32'h0); endproperty
	property p_neg; bin |-> o_flags[`FLAG_NEGATIVE] == o_accumulator[31]; endproperty
	property p_quot; fin && op_reg == `OP_QUOTIENT_BINARY16 && b_reg != 16'h0 |->
		o_accumulator == a_reg / b_reg && o_stack_first == a_reg % b_reg; endproperty
	property p_range; fin && op_reg == `OP_QUOTIENT_BINARY16 && b_reg == 16'h0 |->
		o_flags[`FLAG_OPERAND_RANGE] && o_accumulator == a_reg; endproperty
	property p_pair; take && i_op_code == `OP_QUOTIENT_BCD32 |=> s_word_lo ##[1:2] s_word_hi; endproperty
	property p_ptr; o_op_done && op_reg == `OP_QUOTIENT_FLOAT && pb_reg |-> o_flags[`FLAG_BAD_POINTER]; endproperty
	a_sum: assert property (p_sum) else $error("sum value wrong");
	a_carry: assert property (p_carry) else $error("carry16 wrong");
	a_diff: assert property (p_diff) else $error("difference or borrow wrong");
	a_prod: assert property (p_prod) else $error("product wrong");
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	a_neg: assert property (p_neg) else $error("negative flag wrong");
	a_quot: assert property (p_quot) else $error("quotient or remainder wrong");
	a_range: assert property (p_range) else $error("range flag wrong");
	a_pair: assert property (p_pair) else $error("word pair read wrong");
	a_ptr: assert property (p_ptr) else $error("bad pointer flag missing");
endmodule // accumulator_math_unit_properties
`default_nettype wire

// ---- dv/accumulator_math_unit_tb_top.sv ----
// testbench for the accumulator math unit
`timescale 1ns/100ps
`default_nettype none
`include "acc_math_defs.vh"
module accumulator_math_unit_tb_top;
	logic        i_clk_sys = 1'b0;     // system clock
	logic        i_reset_n = 1'b0;     // sync reset, active low
	logic        i_op_valid = 1'b0;    // request
	logic [3:0]  i_op_code = 4'h0;     // operation
	logic        i_op_immediate = 1'b0; // constant operand
	logic [31:0] i_op_constant = 32'h0; // constant value
	logic [15:0] i_op_addr = 16'h0;    // operand address
	logic        i_op_pointer_bad = 1'b0; // pointer fault
	logic        i_acc_load = 1'b0;    // accumulator load
	logic [31:0] i_acc_load_value = 32'h0; // load value
	wire         o_op_ready, o_op_done, o_mem_rd, o_mem_wr;
	wire  [15:0] o_mem_addr, o_mem_wdata, i_mem_rdata;
	wire  [31:0] o_accumulator, o_stack_first;
	wire  [11:0] o_flags;
	int          checks = 0;           // comparisons made
	int          fail_count = 0;       // mismatches seen
	accumulator_math_unit #(.ADDR_W(16)) i_accumulator_math_unit (.i_clk_sys, .i_reset_n, .i_op_valid,
		.i_op_code, .i_op_immediate, .i_op_constant, .i_op_addr, .i_op_pointer_bad, .o_op_ready, .o_op_done,
		.i_acc_load, .i_acc_load_value, .o_mem_rd, .o_mem_wr, .o_mem_addr, .o_mem_wdata, .i_mem_rdata,
		.o_accumulator, .o_stack_first, .o_flags);
	acc_math_mem_model #(.ADDR_W(16)) i_acc_math_mem_model (.i_clk_sys, .i_rd(o_mem_rd), .i_wr(o_mem_wr),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	always #5 i_clk_sys = ~i_clk_sys;
	// compare one value and count it
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chkf(input int idx, input logic e);
		check($sformatf("flag%0d", idx), {31'h0, e}, {31'h0, o_flags[idx]});
	endtask
	// load the accumulator, issue one op, wait a bounded time for done
	task automatic run(input logic [3:0] code, input logic imm, input logic [31:0] acc, input logic [31:0] k);
		int n;
		@(negedge i_clk_sys);
		i_acc_load = 1'b1;
		i_acc_load_value = acc;
		@(negedge i_clk_sys);
		i_acc_load = 1'b0;
		i_op_valid = 1'b1;
		i_op_code = code;
		i_op_immediate = imm;
		i_op_constant = k;
		@(negedge i_clk_sys);
		i_op_valid = 1'b0;
		n = 0;
		while (o_op_done !== 1'b1 && n < 100) begin
			@(negedge i_clk_sys);
			n++;
		end
		if (o_op_done !== 1'b1) begin
			fail_count++;
			complete_run();
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge i_clk_sys);
		i_reset_n = 1'b1;
		// binary arithmetic on constants
		run(`OP_SUM_BINARY16, 1'b1, 32'h1234FFFF, 32'h1);
		check("sum", 32'h00010000, o_accumulator);
		chkf(`FLAG_CARRY16, 1'b1);
		run(`OP_PRODUCT_BINARY16, 1'b1, 32'h1234, 32'h0100);
		check("product", 32'h00123400, o_accumulator);
		chkf(`FLAG_CARRY16, 1'b1);
		run(`OP_SUM_BINARY16, 1'b1, 32'h0, 32'h0);
		chkf(`FLAG_ZERO, 1'b1);
		run(`OP_SUM_BINARY16, 1'b1, 32'h7FFF, 32'h1);
		chkf(`FLAG_SIGN_ERROR, 1'b1);
		run(`OP_DIFFERENCE_BINARY16, 1'b1, 32'h5, 32'h6);
		check("difference", 32'hFFFFFFFF, o_accumulator);
		chkf(`FLAG_BORROW16, 1'b1);
		chkf(`FLAG_BORROW32, 1'b1);
		chkf(`FLAG_NEGATIVE, 1'b1);
		run(`OP_QUOTIENT_BINARY16, 1'b1, 32'd100, 32'h7);
		check("quotient", 32'd14, o_accumulator);
		check("remainder", 32'h2, o_stack_first);
		run(`OP_QUOTIENT_BINARY16, 1'b1, 32'd100, 32'h0);
		chkf(`FLAG_OPERAND_RANGE, 1'b1);
		$display("test binary done");
		// bcd divides, the wide one from a word pair
		run(`OP_QUOTIENT_BCD16, 1'b1, 32'h1234, 32'h10);
		check("bcd16", 32'h0123, o_accumulator);
		check("bcd16 rem", 32'h4, o_stack_first);
		run(`OP_QUOTIENT_BCD16, 1'b1, 32'h12A4, 32'h10);
		chkf(`FLAG_INVALID_VALUE, 1'b1);
		i_acc_math_mem_model.mem[8'h10] = 16'h0000;
		i_acc_math_mem_model.mem[8'h11] = 16'h0001;
		i_op_addr = 16'h0010;
		run(`OP_QUOTIENT_BCD32, 1'b0, 32'h00123456, 32'h0);
		check("bcd32", 32'h12, o_accumulator);
		check("bcd32 rem", 32'h3456, o_stack_first);
		// bcd counting in memory, once per request
		i_acc_math_mem_model.mem[8'h20] = 16'h0899;
		i_op_addr = 16'h0020;
		run(`OP_COUNT_UP_BCD, 1'b0, 32'h0, 32'h0);
		check("count up", 32'h0900, {16'h0, i_acc_math_mem_model.mem[8'h20]});
		run(`OP_COUNT_DOWN_BCD, 1'b0, 32'h0, 32'h0);
		check("count down", 32'h0899, {16'h0, i_acc_math_mem_model.mem[8'h20]});
		i_acc_math_mem_model.mem[8'h20] = 16'h00A0;
		run(`OP_COUNT_UP_BCD, 1'b0, 32'h0, 32'h0);
		chkf(`FLAG_INVALID_VALUE, 1'b1);
		$display("test bcd done");
		// real divide, single precision operands
		run(`OP_QUOTIENT_FLOAT, 1'b1, 32'h40C00000, 32'h40000000);
		check("real", 32'h40400000, o_accumulator);
		chkf(`FLAG_REAL_VALID, 1'b1);
		run(`OP_QUOTIENT_FLOAT, 1'b1, 32'h00800000, 32'h40000000);
		chkf(`FLAG_UNDERFLOW, 1'b1);
		run(`OP_QUOTIENT_FLOAT, 1'b1, 32'h7FC00000, 32'h40000000);
		chkf(`FLAG_INVALID_VALUE, 1'b1);
		run(`OP_QUOTIENT_FLOAT, 1'b1, 32'h7F000000, 32'h00800000);
		chkf(`FLAG_SIGN_ERROR, 1'b1);
		i_acc_math_mem_model.mem[8'h30] = 16'h0000;
		i_acc_math_mem_model.mem[8'h31] = 16'h4000;
		i_op_addr = 16'h0030;
		i_op_pointer_bad = 1'b1;
		run(`OP_QUOTIENT_FLOAT, 1'b0, 32'h40C00000, 32'h0);
		chkf(`FLAG_BAD_POINTER, 1'b1);
		$display("test real done");
		complete_run();
	end
endmodule // accumulator_math_unit_tb_top
bind accumulator_math_unit accumulator_math_unit_properties #(.ADDR_W(ADDR_W)) i_accumulator_math_unit_properties (
	.i_clk_sys, .i_reset_n, .i_op_valid, .i_op_code, .i_op_immediate, .i_op_constant, .i_op_addr,
	.i_op_pointer_bad, .o_op_ready, .o_op_done, .o_mem_rd, .o_mem_addr, .o_accumulator, .o_stack_first, .o_flags);
`default_nettype wire

// ---- rtl/acc_math_defs.vh ----
// constants for the accumulator math unit
`ifndef ACC_MATH_DEFS_VH
`define ACC_MATH_DEFS_VH
// operation codes
`define OP_QUOTIENT_BCD16     4'h1
`define OP_QUOTIENT_BCD32     4'h2
`define OP_QUOTIENT_FLOAT     4'h3
`define OP_COUNT_UP_BCD       4'h4
`define OP_COUNT_DOWN_BCD     4'h5
`define OP_SUM_BINARY16       4'h6
`define OP_DIFFERENCE_BINARY16 4'h7
`define OP_PRODUCT_BINARY16   4'h8
`define OP_QUOTIENT_BINARY16  4'h9
// flag vector bit positions
`define FLAG_OPERAND_RANGE    0
`define FLAG_ZERO             1
`define FLAG_BORROW16         2
`define FLAG_BORROW32         3
`define FLAG_CARRY16          4
`define FLAG_CARRY32          5
`define FLAG_NEGATIVE         6
`define FLAG_BAD_POINTER      7
`define FLAG_REAL_VALID       8
`define FLAG_SIGN_ERROR       9
`define FLAG_UNDERFLOW        10
`define FLAG_INVALID_VALUE    11
`define FLAG_COUNT            12
// divider iterations
`define DIV_STEPS             6'h20
`endif

// ---- rtl/accumulator_math_unit.v ----
// accumulator math unit: bcd/binary/real divide, bcd count, binary add/sub/mul
// Functional notes
// - bcd16 divide of accumulator by word or constant
// - bcd32 divide by two consecutive memory words
// - quotient to accumulator, remainder to stack
// - real divide by constant or memory pair
// - operands are ieee single precision
// - count-up adds one to bcd word
// - count-down subtracts one from bcd word
// - binary sum, low 16 bits, 32-bit result
// - binary difference of 16-bit operand
// - binary product gives up to 32 bits
// - binary quotient with quotient/remainder placement
// - zero flag when the result is zero (accumulator, or written bcd word for count ops)
// - negative flag when accumulator negative
// - operand range flag on bcd and binary quotient operations
// - invalid flag on illegal bcd nibble
// - sum sets carry16 flag; carry32 is always cleared, as both operands are 16 bits
// - difference sets borrow16 and borrow32 flags
// - sign error flag on signed overflow
// - bad pointer flag on real divide
// - real valid flag while accumulator real
// - underflow flag on real underflow
// - invalid flag on non-real operand
// - flags hold until next operation driving them
`timescale 1ns/100ps
`default_nettype none
`include "acc_math_defs.vh"
module accumulator_math_unit #(
	parameter ADDR_W = 16
) (
	// clock and reset
	input  wire              i_clk_sys,
	input  wire              i_reset_n,
	// operation request from the sequencer
	input  wire              i_op_valid,
	input  wire [3:0]        i_op_code,
	input  wire              i_op_immediate,
	input  wire [31:0]       i_op_constant,
	input  wire [ADDR_W-1:0] i_op_addr,
	input  wire              i_op_pointer_bad,
	output wire              o_op_ready,
	output reg               o_op_done,
	// accumulator load from the sequencer
	input  wire              i_acc_load,
	input  wire [31:0]       i_acc_load_value,
	// data memory port, read data valid one cycle after request
	output reg               o_mem_rd,
	output reg               o_mem_wr,
	output reg  [ADDR_W-1:0] o_mem_addr,
	output reg  [15:0]       o_mem_wdata,
	input  wire [15:0]       i_mem_rdata,
	// results
	output reg  [31:0]       o_accumulator,
	output reg  [31:0]       o_stack_first,
	output reg  [`FLAG_COUNT-1:0] o_flags
);
	// one-hot states
	localparam S_IDLE  = 6'b000001;
	localparam S_RDLO  = 6'b000010;
	localparam S_RDHI  = 6'b000100;
	localparam S_EXEC  = 6'b001000;
	localparam S_DIV   = 6'b010000;
	localparam S_WBACK = 6'b100000;

	reg [5:0]        state_reg;      // sequencer state
	reg [3:0]        op_reg;         // latched operation
	reg              ptr_bad_reg;    // pointer check result
	reg [ADDR_W-1:0] addr_reg;       // operand address
	reg [31:0]       operand_reg;    // assembled operand
	reg [31:0]       dividend_reg;   // divider working quotient
	reg [32:0]       rem_reg;        // divider remainder
	reg [5:0]        step_reg;       // divider step count
	reg              div_bcd_reg;    // divide in bcd form

	// bcd conversion helpers
	function [31:0] bcd_to_bin;
		input [31:0] b;
		integer k;
		reg [31:0] acc;
		begin
			acc = 32'h0;
			for (k = 7; k >= 0; k = k - 1) begin
				acc = (acc * 32'd10) + {28'h0, b[k*4 +: 4]};
			end
			bcd_to_bin = acc;
		end
	endfunction

	function [31:0] bin_to_bcd;
		input [31:0] v;
		integer k;
		reg [31:0] t;
		reg [31:0] r;
		begin
			t = v;
			r = 32'h0;
			for (k = 0; k < 8; k = k + 1) begin
				r = r | ((t % 32'd10) << (k * 4));
				t = t / 32'd10;
			end
			bin_to_bcd = r;
		end
	endfunction

	function bcd_bad;
		input [31:0] b;
		integer k;
		reg bad;
		begin
			bad = 1'b0;
			for (k = 0; k < 8; k = k + 1) begin
				if (b[k*4 +: 4] > 4'h9) begin
					bad = 1'b1;
				end
			end
			bcd_bad = bad;
		end
	endfunction

	// real operand is not a legal number: nan or infinity
	function real_bad;
		input [31:0] f;
		begin
			real_bad = (f[30:23] == 8'hFF);
		end
	endfunction

	// operands for the current operation
	wire        is_bcd_div = (op_reg == `OP_QUOTIENT_BCD16) || (op_reg == `OP_QUOTIENT_BCD32);
	wire [31:0] opnd_bcd32 = is_bcd_div ? operand_reg : 32'h0;
	wire        bcd_in_bad = bcd_bad(o_accumulator) || bcd_bad(opnd_bcd32);
	// decoded from the live op, so a bcd divide after a binary one converts correctly
	wire [31:0] div_num    = is_bcd_div ? bcd_to_bin(o_accumulator) : o_accumulator;
	wire [31:0] div_den    = is_bcd_div ? bcd_to_bin(operand_reg) : operand_reg;

	// binary arithmetic results
	wire [16:0] sum16   = {1'b0, o_accumulator[15:0]} + {1'b0, operand_reg[15:0]};
	wire [32:0] sum32   = {17'h0, o_accumulator[15:0]} + {17'h0, operand_reg[15:0]};
	wire [16:0] diff16  = {1'b0, o_accumulator[15:0]} - {1'b0, operand_reg[15:0]};
	wire [32:0] diff32  = {1'b0, o_accumulator} - {17'h0, operand_reg[15:0]};
	wire [31:0] prod32  = o_accumulator[15:0] * operand_reg[15:0];
	// signed overflow: same input signs give opposite result sign
	wire        sum_ovf = ~(o_accumulator[15] ^ operand_reg[15]) & (sum16[15] ^ o_accumulator[15]);

	// bcd count results
	wire [31:0] cnt_bin  = bcd_to_bin({16'h0, operand_reg[15:0]});
	wire [31:0] cnt_up   = bin_to_bcd((cnt_bin == 32'd9999) ? 32'h0 : cnt_bin + 32'd1);
	wire [31:0] cnt_down = bin_to_bcd((cnt_bin == 32'd0) ? 32'd9999 : cnt_bin - 32'd1);

	// real divide, truncating single precision
	wire        fa_zero = (o_accumulator[30:23] == 8'h00);
	wire        fb_zero = (operand_reg[30:23] == 8'h00);
	wire [47:0] fa_man  = {1'b1, o_accumulator[22:0], 24'h0};
	wire [23:0] fb_man  = {1'b1, operand_reg[22:0]};
	wire [47:0] fq_full = fa_man / {24'h0, fb_man};
	wire        fq_norm = fq_full[24];
	wire [22:0] fq_man  = fq_norm ? fq_full[23:1] : fq_full[22:0];
	wire [9:0]  fq_exp  = {2'b00, o_accumulator[30:23]} - {2'b00, operand_reg[30:23]} +
	                      10'd126 + {9'h0, fq_norm};
	wire        f_in_bad = real_bad(o_accumulator) || real_bad(operand_reg) || fb_zero;
	wire        f_under  = ~fa_zero & (fq_exp[9] | (fq_exp == 10'h0));
	wire        f_over   = ~fq_exp[9] & (fq_exp[8] | (fq_exp[7:0] == 8'hFF));
	wire [31:0] f_result = (fa_zero | f_under) ? 32'h0 :
	                       {o_accumulator[31] ^ operand_reg[31], fq_exp[7:0], fq_man};

	// constant operand: legal only for some ops, 16 bits wide except for real
	wire        use_imm   = i_op_immediate && (i_op_code != `OP_QUOTIENT_BCD32) &&
	                        (i_op_code != `OP_COUNT_UP_BCD) && (i_op_code != `OP_COUNT_DOWN_BCD);
	wire [31:0] k_operand = (i_op_code == `OP_QUOTIENT_FLOAT) ? i_op_constant : {16'h0, i_op_constant[15:0]};

	assign o_op_ready = (state_reg == S_IDLE);

	// main sequencer
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			state_reg     <= S_IDLE;
			op_reg        <= 4'h0;
			ptr_bad_reg   <= 1'b0;
			addr_reg      <= {ADDR_W{1'b0}};
			operand_reg   <= 32'h0;
			dividend_reg  <= 32'h0;
			rem_reg       <= 33'h0;
			step_reg      <= 6'h0;
			div_bcd_reg   <= 1'b0;
			o_op_done     <= 1'b0;
			o_mem_rd      <= 1'b0;
			o_mem_wr      <= 1'b0;
			o_mem_addr    <= {ADDR_W{1'b0}};
			o_mem_wdata   <= 16'h0;
			o_accumulator <= 32'h0;
			o_stack_first <= 32'h0;
			o_flags       <= {`FLAG_COUNT{1'b0}};
		end else begin
			o_op_done <= 1'b0;
			o_mem_rd  <= 1'b0;
			o_mem_wr  <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					// accumulator load only while idle
					if (i_acc_load) begin
						o_accumulator <= i_acc_load_value;
					end
					if (i_op_valid) begin
						op_reg      <= i_op_code;
						ptr_bad_reg <= i_op_pointer_bad;
						addr_reg    <= i_op_addr;
						// count ops always use memory; bcd32 immediate is illegal and ignored
						operand_reg <= k_operand;
						if (use_imm) begin
							state_reg <= S_EXEC;
						end else begin
							o_mem_rd   <= 1'b1;
							o_mem_addr <= i_op_addr;
							state_reg  <= S_RDLO;
						end
					end
				end
				S_RDLO: begin
					// lower word at the given address
					operand_reg <= {16'h0, i_mem_rdata};
					if ((op_reg == `OP_QUOTIENT_BCD32) || (op_reg == `OP_QUOTIENT_FLOAT)) begin
						o_mem_rd   <= 1'b1;
						o_mem_addr <= addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
						state_reg  <= S_RDHI;
					end else begin
						state_reg <= S_EXEC;
					end
				end
				S_RDHI: begin
					// upper word at the following address
					operand_reg[31:16] <= i_mem_rdata;
					state_reg <= S_EXEC;
				end
				S_EXEC: begin
					state_reg <= S_IDLE;
					o_op_done <= 1'b1;
					case (op_reg)
						`OP_QUOTIENT_BCD16, `OP_QUOTIENT_BCD32, `OP_QUOTIENT_BINARY16: begin
							div_bcd_reg <= is_bcd_div;
							if ((is_bcd_div && bcd_in_bad) || (div_den == 32'h0)) begin
								// divide refused; accumulator kept
								o_flags[`FLAG_INVALID_VALUE] <= is_bcd_div & bcd_in_bad;
								o_flags[`FLAG_OPERAND_RANGE] <= (div_den == 32'h0);
							end else begin
								o_op_done    <= 1'b0;
								dividend_reg <= div_num;
								rem_reg      <= 33'h0;
								step_reg     <= `DIV_STEPS;
								state_reg    <= S_DIV;
							end
						end
						`OP_QUOTIENT_FLOAT: begin
							if (!f_in_bad && !f_over) begin
								o_accumulator <= f_result;
							end
							o_flags[`FLAG_BAD_POINTER]   <= ptr_bad_reg;
							o_flags[`FLAG_INVALID_VALUE] <= f_in_bad;
							o_flags[`FLAG_UNDERFLOW]     <= ~f_in_bad & f_under;
							o_flags[`FLAG_SIGN_ERROR]    <= ~f_in_bad & f_over;
							o_flags[`FLAG_REAL_VALID]    <= ~f_in_bad & ~f_over;
							o_flags[`FLAG_ZERO]          <= ~f_in_bad & ~f_over & ((f_result[30:0] == 31'h0));
							o_flags[`FLAG_NEGATIVE]      <= ~f_in_bad & ~f_over & f_result[31] &
							                                (f_result[30:0] != 31'h0);
						end
						`OP_COUNT_UP_BCD, `OP_COUNT_DOWN_BCD: begin
							o_flags[`FLAG_INVALID_VALUE] <= bcd_bad({16'h0, operand_reg[15:0]});
							if (!bcd_bad({16'h0, operand_reg[15:0]})) begin
								o_op_done   <= 1'b0;
								o_mem_wr    <= 1'b1;
								o_mem_addr  <= addr_reg;
								o_mem_wdata <= (op_reg == `OP_COUNT_UP_BCD) ? cnt_up[15:0] : cnt_down[15:0];
								o_flags[`FLAG_ZERO] <= (((op_reg == `OP_COUNT_UP_BCD) ? cnt_up[15:0] :
								                         cnt_down[15:0]) == 16'h0);
								state_reg   <= S_WBACK;
							end
						end
						`OP_SUM_BINARY16: begin
							o_accumulator <= sum32[31:0];
							o_flags[`FLAG_CARRY16]    <= sum16[16];
							o_flags[`FLAG_CARRY32]    <= sum32[32];
							o_flags[`FLAG_SIGN_ERROR] <= sum_ovf;
							o_flags[`FLAG_ZERO]       <= (sum32[31:0] == 32'h0);
							o_flags[`FLAG_NEGATIVE]   <= sum32[31];
						end
						`OP_DIFFERENCE_BINARY16: begin
							o_accumulator <= diff32[31:0];
							o_flags[`FLAG_BORROW16]  <= diff16[16];
							o_flags[`FLAG_BORROW32]  <= diff32[32];
							o_flags[`FLAG_ZERO]      <= (diff32[31:0] == 32'h0);
							o_flags[`FLAG_NEGATIVE]  <= diff32[31];
						end
						`OP_PRODUCT_BINARY16: begin
							o_accumulator <= prod32;
							o_flags[`FLAG_ZERO]     <= (prod32 == 32'h0);
							o_flags[`FLAG_NEGATIVE] <= prod32[31];
						end
						default: begin
							// unknown code: no effect, flags untouched
						end
					endcase
				end
				S_DIV: begin
					// restoring divide, one bit per cycle
					if (step_reg == 6'h0) begin
						state_reg <= S_IDLE;
						o_op_done <= 1'b1;
						// quotient to accumulator, remainder to stack
						o_accumulator <= div_bcd_reg ? bin_to_bcd(dividend_reg) : dividend_reg;
						o_stack_first <= div_bcd_reg ? bin_to_bcd(rem_reg[31:0]) : rem_reg[31:0];
						o_flags[`FLAG_ZERO]          <= (dividend_reg == 32'h0);
						o_flags[`FLAG_NEGATIVE]      <= ~div_bcd_reg & dividend_reg[31];
						o_flags[`FLAG_OPERAND_RANGE] <= div_bcd_reg & (dividend_reg > 32'd99999999);
						o_flags[`FLAG_INVALID_VALUE] <= 1'b0;
					end else begin
						step_reg <= step_reg - 6'h1;
						if ({rem_reg[31:0], dividend_reg[31]} >= {1'b0, div_den}) begin
							rem_reg      <= {rem_reg[31:0], dividend_reg[31]} - {1'b0, div_den};
							dividend_reg <= {dividend_reg[30:0], 1'b1};
						end else begin
							rem_reg      <= {rem_reg[31:0], dividend_reg[31]};
							dividend_reg <= {dividend_reg[30:0], 1'b0};
						end
					end
				end
				S_WBACK: begin
					// write issued last cycle; report done
					state_reg <= S_IDLE;
					o_op_done <= 1'b1;
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end
endmodule // accumulator_math_unit
`default_nettype wire
